// >>> design/sfu_flags.sv
/*
  Control and status flag update logic of a two-wire bus interface, with
  APB register access and a level interrupt.
  Every flag is a sys_clk register that moves on the edge after its cause,
  so software never reads a half-updated status word.
  Register map: control, status mirror, data byte, sticky interrupt status
  and interrupt mask, one aligned 32-bit word each, zero wait states.
  Interrupt status bits are separate from the flags, so clearing one
  leaves the other untouched.
  Assumes the shifter supplies bus condition pulses on sys_clk, and the
  raw SCL and SDA pin levels arrive asynchronously.
  Assumes each condition pulse lasts exactly one cycle; a longer pulse
  would be seen as several events by the sticky bits.
  Assumes context levels from the shifter are steady while the pins are
  being compared, since the pin path lags by two cycles.
  Assumes one sys_clk domain for the register bus and the shifter, and an
  asynchronous active high reset released clear of a clock edge.
  Limitation: unmapped offsets answer with an error and read as zero;
  no byte strobes, so every write replaces the whole register.
  Limitation: pin based arbitration loss reacts two cycles after the wire
  moves, which is short against any bus bit time.
*/
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Set owner flag on own START
// - Clear owner on own STOP or arbitration loss
// - Set transmit flag on START or early data write
// - Clear transmit on START seen, loss, no write
// - Set start request on START plus address
// - Set stop request on STOP when addressed
// - Set stop request on loss by STOP
// - Clear stop request after pending STOP sent
// - Set ack-needed on byte without hardware ack
// - Clear ack-needed after ack cycle; same-cycle set wins
// - Arbitration fail on unwanted repeated START
// - Arbitration fail on SCL low at STOP
// - Arbitration fail on SDA low sending one
// - Clear arbitration fail with serial flag
// - Capture received acknowledge as ack value
// - Set serial flag on bus events, software clears
module sfu_flags (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Bus pins, raw
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  // Bus condition pulses and context from the shifter
  input  wire sfu_pkg::sfu_evt_t evt,
  input  wire sfu_pkg::sfu_ctx_t ctx,
  // Flag outputs to the shifter
  output logic                   bus_owner_flag,
  output logic                   transmit_direction_flag,
  output logic                   start_request_flag,
  output logic                   stop_request_flag,
  output logic                   ack_needed_flag,
  output logic                   arbitration_fail_flag,
  output logic                   ack_value_bit,
  output logic                   serial_event_flag,
  output logic                   hw_ack_enable,
  output logic                   ack_response,
  output logic      [7:0]        bus_data_byte,
  // Interrupt
  output logic                   irq
);

  logic [1:0]                     pins_s;
  logic                           scl_s;
  logic                           sda_s;
  logic                           wr_acc;
  logic                           rd_acc;
  logic                           wr_ctrl;
  logic                           data_written_r;
  logic                           arb_lost;
  logic                           arb_by_stop;
  logic                           serial_clr;
  logic                           hw_ack_r;
  logic                           ack_resp_r;
  logic [7:0]                     data_r;
  logic [sfu_pkg::SFU_IRQ_W-1:0]  irq_stat_r;
  logic [sfu_pkg::SFU_IRQ_W-1:0]  irq_mask_r;
  logic [sfu_pkg::SFU_IRQ_W-1:0]  irq_evt;
  logic                           sel_ctrl;
  logic                           sel_stat;
  logic                           sel_data;
  logic                           sel_irq;
  logic                           sel_mask;

  // Decode helper used for each register
  // Kept as a function so every offset compares the same way
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Pin synchroniser
  // Two stages against metastability; pins idle high out of reset
  sfu_sync #(
    .WIDTH    (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Offset decode, shared by strobes and error
  // One compare per register keeps the decode flat and cheap
  assign sel_ctrl = hit(paddr, sfu_pkg::SFU_CTRL_OFS);
  assign sel_stat = hit(paddr, sfu_pkg::SFU_STAT_OFS);
  assign sel_data = hit(paddr, sfu_pkg::SFU_DATA_OFS);
  assign sel_irq  = hit(paddr, sfu_pkg::SFU_IRQ_OFS);
  assign sel_mask = hit(paddr, sfu_pkg::SFU_MASK_OFS);

  // APB access phase strobes; zero wait states
  // Nothing here needs a wait, so pready is simply tied high
  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign wr_ctrl = wr_acc & sel_ctrl;
  assign pslverr = psel & penable &
                   ~(sel_ctrl | sel_stat | sel_data | sel_irq | sel_mask);

  // Software clears serial flag by writing zero to its control bit
  assign serial_clr = wr_ctrl & ~pwdata[sfu_pkg::SFU_B_SERIAL];

  // Arbitration loss sources
  // The repeated START term excludes our own START, which the detector
  // also reports; without that a master would flag a loss on itself.
  // The pin terms use the synchronised copies, never the raw pins.
  // A loss by STOP is a STOP seen while owning without making it.
  assign arb_by_stop = evt.stop_det & bus_owner_flag & ~evt.stop_gen;
  assign arb_lost = (evt.start_det & bus_owner_flag & ~start_request_flag & ~evt.start_gen) |
                    (ctx.gen_stop_rs & ~scl_s) |
                    (ctx.tx_data_bit & ctx.tx_bit_one & ~ctx.ack_bit & ~sda_s) |
                    arb_by_stop;

  // Software control bits and data byte
  // Held until software rewrites them; hardware never touches these
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hw_ack_r   <= 1'b0;
      ack_resp_r <= 1'b0;
      data_r     <= sfu_pkg::SFU_DATA_RST;
    end else begin
      if (wr_ctrl) begin
        hw_ack_r   <= pwdata[sfu_pkg::SFU_B_HWACK];
        ack_resp_r <= pwdata[sfu_pkg::SFU_B_ACKOUT];
      end
      if (wr_acc && hit(paddr, sfu_pkg::SFU_DATA_OFS)) begin
        data_r <= pwdata[7:0];
      end
    end
  end

  // Remember a data write ahead of the next frame
  // Cleared at frame start, where a same-cycle data write wins, so a stale write cannot set direction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_written_r <= 1'b0;
    end else if (wr_acc && hit(paddr, sfu_pkg::SFU_DATA_OFS)) begin
      data_written_r <= 1'b1;
    end else if (evt.frame_begin) begin
      data_written_r <= 1'b0;
    end
  end

  // Bus ownership; loss beats a same-cycle START
  // Stop and loss both end ownership, so they share one branch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_owner_flag <= 1'b0;
    end else if (evt.stop_gen || arb_lost) begin
      bus_owner_flag <= 1'b0;
    end else if (evt.start_gen) begin
      bus_owner_flag <= 1'b1;
    end
  end

  // Transmit direction; own START outranks the detected START it causes
  // A frame start copies whether data was written since the last one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transmit_direction_flag <= 1'b0;
    end else if (arb_lost) begin
      transmit_direction_flag <= 1'b0;
    end else if (evt.start_gen) begin
      transmit_direction_flag <= 1'b1;
    end else if (evt.start_det) begin
      transmit_direction_flag <= 1'b0;
    end else if (evt.frame_begin) begin
      transmit_direction_flag <= data_written_r;
    end
  end

  // Start request: hardware sets, only software clears; set wins
  // A software write of one requests a START from the shifter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_request_flag <= 1'b0;
    end else if (evt.start_det && evt.addr_rx) begin
      start_request_flag <= 1'b1;
    end else if (wr_ctrl) begin
      start_request_flag <= pwdata[sfu_pkg::SFU_B_START];
    end
  end

  // Stop request: hardware set wins over software and auto clear
  // Auto clear needs a pending request, else an own STOP changes nothing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stop_request_flag <= 1'b0;
    end else if (evt.stop_det && ctx.addressed_slave) begin
      stop_request_flag <= 1'b1;
    end else if (arb_by_stop) begin
      stop_request_flag <= 1'b1;
    end else if (evt.stop_gen && stop_request_flag) begin
      stop_request_flag <= 1'b0;
    end else if (wr_ctrl) begin
      stop_request_flag <= pwdata[sfu_pkg::SFU_B_STOP];
    end
  end

  // Acknowledge needed, only without hardware acknowledge
  // With hardware acknowledge on, the shifter answers on its own
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_needed_flag <= 1'b0;
    end else if (evt.byte_rx && !hw_ack_r && ctx.ack_value_needed) begin
      ack_needed_flag <= 1'b1;
    end else if (evt.ack_cycle_end) begin
      ack_needed_flag <= 1'b0;
    end
  end

  // Arbitration failure; a new loss beats the clear
  // Clearing rides on the serial flag clear, one software write for both
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arbitration_fail_flag <= 1'b0;
    end else if (arb_lost) begin
      arbitration_fail_flag <= 1'b1;
    end else if (serial_clr) begin
      arbitration_fail_flag <= 1'b0;
    end
  end

  // Received acknowledge capture; low on the wire reads as one
  // Holds its value between acknowledge cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_value_bit <= 1'b0;
    end else if (evt.ack_sampled) begin
      ack_value_bit <= evt.ack_low;
    end
  end

  // Serial event flag; set beats software clear
  // Software clears by writing zero; writing one leaves it alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_event_flag <= 1'b0;
    end else if (evt.start_gen || arb_lost || evt.byte_tx_acked || evt.byte_rx) begin
      serial_event_flag <= 1'b1;
    end else if (serial_clr) begin
      serial_event_flag <= 1'b0;
    end
  end

  // Sticky interrupt causes
  // Serial event cause takes the serial flag's set terms except arbitration loss, which has its own cause
  assign irq_evt[sfu_pkg::SFU_I_SERIAL] = evt.start_gen | evt.byte_tx_acked | evt.byte_rx;
  assign irq_evt[sfu_pkg::SFU_I_ARB]    = arb_lost;
  assign irq_evt[sfu_pkg::SFU_I_STOPRX] = evt.stop_det & ctx.addressed_slave;

  // Read of status clears it, new events in that cycle survive
  // Keeping the same-cycle event means no cause is ever lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else if (rd_acc && hit(paddr, sfu_pkg::SFU_IRQ_OFS)) begin
      irq_stat_r <= irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // Interrupt mask
  // Masked causes still collect in status and can be polled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask_r <= sfu_pkg::SFU_MASK_RST;
    end else if (wr_acc && hit(paddr, sfu_pkg::SFU_MASK_OFS)) begin
      irq_mask_r <= pwdata[sfu_pkg::SFU_IRQ_W-1:0];
    end
  end

  // Level interrupt, high while any unmasked status bit is set
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read mux; flags are registered so software sees stable values
  // Write cycles and idle cycles return zero to keep the bus quiet
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (hit(paddr, sfu_pkg::SFU_CTRL_OFS) || hit(paddr, sfu_pkg::SFU_STAT_OFS)) begin
        prdata[sfu_pkg::SFU_B_SERIAL] = serial_event_flag;
        prdata[sfu_pkg::SFU_B_START]  = start_request_flag;
        prdata[sfu_pkg::SFU_B_STOP]   = stop_request_flag;
        prdata[sfu_pkg::SFU_B_ACKOUT] = ack_resp_r;
        prdata[sfu_pkg::SFU_B_HWACK]  = hw_ack_r;
        prdata[sfu_pkg::SFU_B_OWNER]  = bus_owner_flag;
        prdata[sfu_pkg::SFU_B_TXDIR]  = transmit_direction_flag;
        prdata[sfu_pkg::SFU_B_ACKRQ]  = ack_needed_flag;
        prdata[sfu_pkg::SFU_B_ARB]    = arbitration_fail_flag;
        prdata[sfu_pkg::SFU_B_ACKVAL] = ack_value_bit;
      end else if (hit(paddr, sfu_pkg::SFU_DATA_OFS)) begin
        prdata[7:0] = data_r;
      end else if (hit(paddr, sfu_pkg::SFU_IRQ_OFS)) begin
        prdata[sfu_pkg::SFU_IRQ_W-1:0] = irq_stat_r;
      end else if (hit(paddr, sfu_pkg::SFU_MASK_OFS)) begin
        prdata[sfu_pkg::SFU_IRQ_W-1:0] = irq_mask_r;
      end
    end
  end

  // Software settings handed on to the shifter
  assign hw_ack_enable = hw_ack_r;
  assign ack_response  = ack_resp_r;
  assign bus_data_byte = data_r;

endmodule : sfu_flags
`default_nettype wire

// >>> design/sfu_pkg.sv
/*
  Package for the bus flag update block: register offsets, field positions,
  reset values, bus event carrier and context types.
  Assumes an APB master with 32-bit data and aligned word offsets.
*/
package sfu_pkg;

  // Register byte offsets
  localparam logic [7:0] SFU_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SFU_STAT_OFS   = 8'h04;
  localparam logic [7:0] SFU_DATA_OFS   = 8'h08;
  localparam logic [7:0] SFU_IRQ_OFS    = 8'h0C;
  localparam logic [7:0] SFU_MASK_OFS   = 8'h10;

  // Control and status field positions
  localparam int SFU_B_SERIAL = 0;
  localparam int SFU_B_START  = 1;
  localparam int SFU_B_STOP   = 2;
  localparam int SFU_B_ACKOUT = 3;
  localparam int SFU_B_HWACK  = 4;
  localparam int SFU_B_OWNER  = 5;
  localparam int SFU_B_TXDIR  = 6;
  localparam int SFU_B_ACKRQ  = 7;
  localparam int SFU_B_ARB    = 8;
  localparam int SFU_B_ACKVAL = 9;

  // Interrupt status layout
  localparam int SFU_IRQ_W     = 3;
  localparam int SFU_I_SERIAL  = 0;
  localparam int SFU_I_ARB     = 1;
  localparam int SFU_I_STOPRX  = 2;

  // Reset values
  localparam logic [7:0]           SFU_DATA_RST = 8'h00;
  localparam logic [SFU_IRQ_W-1:0] SFU_MASK_RST = 3'h0;

  // Synchroniser depth
  localparam int SFU_SYNC_STAGES = 2;

  // Recognised bus conditions, one cycle pulses
  typedef struct packed {
    logic start_gen;
    logic stop_gen;
    logic start_det;
    logic stop_det;
    logic addr_rx;
    logic byte_rx;
    logic byte_tx_acked;
    logic ack_cycle_end;
    logic ack_sampled;
    logic ack_low;
    logic frame_begin;
  } sfu_evt_t;

  // Device activity context, levels
  typedef struct packed {
    logic addressed_slave;
    logic gen_stop_rs;
    logic tx_data_bit;
    logic tx_bit_one;
    logic ack_bit;
    logic ack_value_needed;
  } sfu_ctx_t;

endpackage : sfu_pkg

// >>> design/sfu_sync.sv
/*
  Two-stage synchroniser for the bus pins.
  Assumes inputs arrive from outside the sys_clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sfu_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage read only by second; idle bus level is high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : sfu_sync
`default_nettype wire

// >>> verification/sfu_bus_peer.sv
/*
  Far-side bus party: open-drain SCL and SDA with pull-ups.
  Assumes the bench commands frames and pull-downs.
*/
`timescale 1ns/100ps
`default_nettype none
module sfu_bus_peer (
  // Commands from the bench
  input  wire logic frame,
  input  wire logic scl_low,
  input  wire logic sda_low,
  // Wire levels
  output logic      scl,
  output logic      sda
);
  logic clk_r;
  // Link clock of 80 ns, parked high between frames
  initial begin
    clk_r = 1'b1;
    #7;
    forever #40 clk_r = frame ? ~clk_r : 1'b1;
  end
  // Released lines float to the pull-up level
  assign scl = clk_r & ~scl_low;
  assign sda = ~sda_low;
endmodule : sfu_bus_peer
`default_nettype wire

// >>> verification/sfu_flags_sva.sv
/*
  Checker for the bus flag update block.
  Assumes only the sfu_flags ports; bound into it below.
*/
`timescale 1ns/100ps
`default_nettype none
module sfu_flags_chk (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Register bus and raw pins
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              scl_in,
  input wire logic              sda_in,
  // Events, context and flags
  input wire sfu_pkg::sfu_evt_t evt,
  input wire sfu_pkg::sfu_ctx_t ctx,
  input wire logic              bus_owner_flag,
  input wire logic              transmit_direction_flag,
  input wire logic              start_request_flag,
  input wire logic              stop_request_flag,
  input wire logic              ack_needed_flag,
  input wire logic              arbitration_fail_flag,
  input wire logic              ack_value_bit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Flags follow their cause one cycle later
  a_owner_set: assert property (evt.start_gen && !evt.stop_gen |=> bus_owner_flag && transmit_direction_flag)
    else $error("owner or direction not set");
  a_owner_clr: assert property (evt.stop_gen |=> !bus_owner_flag)
    else $error("owner not cleared");
  a_start_req: assert property (evt.start_det && evt.addr_rx |=> start_request_flag)
    else $error("start request not set");
  a_stop_set: assert property (evt.stop_det && (ctx.addressed_slave || bus_owner_flag && !evt.stop_gen) |=> stop_request_flag)
    else $error("stop request not set");
  a_stop_clr: assert property (evt.stop_gen && !evt.stop_det |=> !stop_request_flag)
    else $error("stop request not cleared");
  a_ackrq_clr: assert property (evt.ack_cycle_end && !evt.byte_rx |=> !ack_needed_flag)
    else $error("ack needed not cleared");
  a_ack_value: assert property (evt.ack_sampled |=> ack_value_bit == $past(evt.ack_low))
    else $error("ack value wrong");
  // Pins pass a two-stage synchroniser first
  a_arb_scl: assert property ((ctx.gen_stop_rs && !scl_in) [*3] |=> arbitration_fail_flag)
    else $error("scl arbitration loss missed");
  a_arb_sda: assert property ((ctx.tx_data_bit && ctx.tx_bit_one && !ctx.ack_bit && !sda_in) [*3]
    |=> arbitration_fail_flag)
    else $error("sda arbitration loss missed");
  a_arb_clr: assert property (psel && penable && pwrite && paddr == sfu_pkg::SFU_CTRL_OFS && !pwdata[0]
    && !evt.start_det && !evt.stop_det && !ctx.gen_stop_rs && !ctx.tx_data_bit
    |=> !arbitration_fail_flag)
    else $error("arbitration fail not cleared");
endmodule : sfu_flags_chk
bind sfu_flags sfu_flags_chk sfu_flags_chk_i (.*);
`default_nettype wire

// >>> verification/tb.sv
/*
  Bench for the bus flag update block: APB tasks and event steps.
  Assumes sfu_pkg, the design, the peer model and checker compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] CTRL = sfu_pkg::SFU_CTRL_OFS;
  localparam logic [7:0] STAT = sfu_pkg::SFU_STAT_OFS;
  logic              sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic              irq, perr, frame, scl_low, sda_low, scl_in, sda_in;
  logic [7:0]        paddr, bus_data_byte;
  logic [31:0]       pwdata, prdata, q;
  int                fails, cmp_count;
  sfu_pkg::sfu_evt_t evt;
  sfu_pkg::sfu_ctx_t ctx;

  sfu_flags sfu_flags_i (.*, .bus_owner_flag(), .transmit_direction_flag(),
    .start_request_flag(), .stop_request_flag(), .ack_needed_flag(),
    .arbitration_fail_flag(), .ack_value_bit(), .serial_event_flag(),
    .hw_ack_enable(), .ack_response());
  sfu_bus_peer sfu_bus_peer_i (.frame, .scl_low, .sda_low, .scl(scl_in), .sda(sda_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      fails++;
    end
  endtask : chk

  // Held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(x, q);
  endtask : rd

  // Context held long enough for the pin synchroniser
  task automatic step(input logic [10:0] e, input logic [5:0] c, input logic [9:0] x);
    @(posedge sys_clk);
    evt <= e;
    ctx <= c;
    @(posedge sys_clk);
    evt <= '0;
    repeat (3) @(posedge sys_clk);
    ctx <= '0;
    rd(STAT, {22'h0, x});
  endtask : step

  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, frame, scl_low, sda_low} = '0;
    {paddr, pwdata, evt, ctx} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, last address unmapped
    for (int a = 0; a < 24; a += 4) rd(8'(a), 32'h0);
    chk(32'h1, {31'h0, perr});
    apb(1'b1, sfu_pkg::SFU_MASK_OFS, 32'h7);
    step(11'h400, 6'h00, 10'h061);
    @(negedge sys_clk);
    chk(32'h1, {31'h0, irq});
    rd(sfu_pkg::SFU_IRQ_OFS, 32'h1);
    @(negedge sys_clk);
    chk(32'h0, {31'h0, irq});
    apb(1'b1, CTRL, 32'h0);
    step(11'h000, 6'h00, 10'h060);
    step(11'h080, 6'h00, 10'h105);
    apb(1'b1, CTRL, 32'h0);
    step(11'h400, 6'h00, 10'h061);
    scl_low <= 1'b1;
    step(11'h000, 6'h10, 10'h101);
    scl_low <= 1'b0;
    apb(1'b1, CTRL, 32'h0);
    step(11'h000, 6'h00, 10'h000);
    frame <= 1'b1;
    step(11'h400, 6'h00, 10'h061);
    apb(1'b1, CTRL, 32'h0);
    sda_low <= 1'b1;
    step(11'h000, 6'h0E, 10'h060);
    step(11'h000, 6'h0C, 10'h101);
    sda_low <= 1'b0;
    frame <= 1'b0;
    apb(1'b1, CTRL, 32'h0);
    step(11'h400, 6'h00, 10'h061);
    step(11'h100, 6'h00, 10'h101);
    apb(1'b1, CTRL, 32'h0);
    step(11'h160, 6'h00, 10'h003);
    step(11'h200, 6'h00, 10'h003);
    apb(1'b1, CTRL, 32'h0);
    step(11'h080, 6'h20, 10'h004);
    step(11'h200, 6'h00, 10'h000);
    apb(1'b1, CTRL, 32'h10);
    step(11'h020, 6'h01, 10'h011);
    apb(1'b1, CTRL, 32'h0);
    step(11'h020, 6'h01, 10'h081);
    step(11'h008, 6'h00, 10'h001);
    step(11'h006, 6'h00, 10'h201);
    step(11'h004, 6'h00, 10'h001);
    apb(1'b1, CTRL, 32'h0);
    step(11'h010, 6'h00, 10'h001);
    apb(1'b1, sfu_pkg::SFU_DATA_OFS, 32'hA5);
    @(negedge sys_clk);
    chk(32'hA5, {24'h0, bus_data_byte});
    step(11'h001, 6'h00, 10'h041);
    step(11'h001, 6'h00, 10'h001);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
